// ---- dac_ctrl_cfg.svh ----
// What this block does
// - Operation 11 in a valid word powers down both channels.
// - Termination 00/11 high-impedance, 01 about 2.5 kOhm, 10 about 100 kOhm.
// - Reset clears both holding registers; outputs read zero until first write with operation 01 or 10.
// - Holding registers keep their contents during power-down.
// - Wake-up keeps old values unless the waking word writes that channel.
// - While frame select is low, shift one bit per falling serial clock edge.
// - At the 16th falling edge capture last bit and execute at once.
// - After the 16th edge ignore clocks and data until frame select rises.
// - First bit is zero and second bit addresses channel A or B, except in power-down words, where both select termination.
// - Third and fourth bits select one of four operations.
// - Last twelve bits are straight binary data, most significant bit first.
// - Frame select rising before 16th edge discards the partial word.
`ifndef DAC_CTRL_CFG_SVH
`define DAC_CTRL_CFG_SVH
`define WORD_BITS      16
`define DATA_BITS      12
`define BIT_CHAN       14
`define BIT_OP_HI      13
`define BIT_OP_LO      12
`define BIT_TERM_HI    15
`define BIT_TERM_LO    14
`define ADDR_CTRL      4'h0
`define ADDR_STATUS    4'h4
`define ADDR_CHAN_A    4'h8
`define ADDR_CHAN_B    4'hc
`define CTRL_ENABLE    0
`define STAT_PDOWN     0
`define STAT_TERM_LO   1
`define STAT_ERR       3
`define STAT_WRITTEN   4
`endif

// ---- dac_ctrl_pkg.sv ----
package dac_ctrl_pkg;
  typedef enum logic [1:0] {
    OP_WRITE_ONE = 2'h0,
    OP_WRITE_UPD = 2'h1,
    OP_WRITE_ALL = 2'h2,
    OP_PDOWN     = 2'h3
  } op_e;
  typedef enum logic [1:0] {
    TERM_HIZ_0  = 2'h0,
    TERM_2K5    = 2'h1,
    TERM_100K   = 2'h2,
    TERM_HIZ_1  = 2'h3
  } term_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } frame_e;
endpackage

// ---- dual_dac_serial_write_control.sv ----
`timescale 1ns/1ns
`include "dac_ctrl_cfg.svh"
module dual_dac_serial_write_control
  import dac_ctrl_pkg::*;
#(
  parameter int DATA_BITS = `DATA_BITS
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 frame_sel_n,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_data,
  output logic [DATA_BITS-1:0]      out_code_a,
  output logic [DATA_BITS-1:0]      out_code_b,
  output logic                      powered_down,
  output logic                      term_2k5,
  output logic                      term_100k,
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // Pin synchronisers: two flops each, first flop read only by second
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic       sclk_d_r;

  always_ff @(posedge aclk)
  begin
    sync1_r  <= {frame_sel_n, serial_clk, serial_data};
    sync2_r  <= sync1_r;
    sclk_d_r <= sync2_r[1];
  end

  wire fs_n     = sync2_r[2];
  wire sclk_s   = sync2_r[1];
  wire sdata_s  = sync2_r[0];
  wire sclk_fall = sclk_d_r & ~sclk_s;

  // Link state
  frame_e                 state_r;
  frame_e                 state_nxt;
  logic [`WORD_BITS-1:0]  shift_r;
  logic [4:0]             count_r;
  logic [DATA_BITS-1:0]   hold_a_r;
  logic [DATA_BITS-1:0]   hold_b_r;
  logic                   pdown_r;
  logic [1:0]             term_r;
  logic                   enable_r;
  logic                   err_r;
  logic                   written_r;

  // Word completes on the 16th falling edge, using the bit arriving now
  wire [`WORD_BITS-1:0] word_full = {shift_r[`WORD_BITS-2:0], sdata_s};
  wire last_edge  = (state_r == ST_SHIFT) & ~fs_n & sclk_fall &
                    (count_r == 5'(`WORD_BITS - 1));
  wire op_hi      = word_full[`BIT_OP_HI];
  wire op_lo      = word_full[`BIT_OP_LO];
  wire chan_b     = word_full[`BIT_CHAN];
  wire lead_ok    = ~word_full[`WORD_BITS-1];
  wire [1:0] op   = {op_hi, op_lo};
  wire [DATA_BITS-1:0] data_w = word_full[DATA_BITS-1:0];
  wire is_pdown   = (op == OP_PDOWN);
  // Power-down words carry termination select in the lead bit, so only
  // data words are refused for a set lead bit
  wire cmd_ok     = lead_ok | is_pdown;
  wire exec       = last_edge & cmd_ok & enable_r;
  wire wr_a       = exec & ~is_pdown &
                    ((op == OP_WRITE_ALL) | ~chan_b);
  wire wr_b       = exec & ~is_pdown &
                    ((op == OP_WRITE_ALL) | chan_b);
  // Op 00 stores but leaves the output codes alone
  wire upd        = exec & (op != OP_WRITE_ONE) & ~is_pdown;
  wire [1:0] term_w = word_full[`BIT_TERM_HI:`BIT_TERM_LO];

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (!fs_n)
          state_nxt = ST_SHIFT;
      ST_SHIFT:
        if (fs_n)
          state_nxt = ST_IDLE;
        else if (last_edge)
          state_nxt = ST_DONE;
      ST_DONE:
        if (fs_n)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      shift_r <= '0;
      count_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r != ST_SHIFT)
      begin
        shift_r <= '0;
        count_r <= '0;
      end
      else if (!fs_n && sclk_fall)
      begin
        shift_r <= word_full;
        count_r <= count_r + 5'd1;
      end
    end
  end

  // Holding registers and output codes; reset clears both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_a_r     <= '0;
      hold_b_r     <= '0;
      out_code_a   <= '0;
      out_code_b   <= '0;
      pdown_r      <= 1'b0;
      term_r       <= 2'h0;
      written_r    <= 1'b0;
    end
    else
    begin
      if (wr_a)
        hold_a_r <= data_w;
      if (wr_b)
        hold_b_r <= data_w;
      if (upd)
      begin
        out_code_a <= wr_a ? data_w : hold_a_r;
        out_code_b <= wr_b ? data_w : hold_b_r;
      end
      if (exec)
      begin
        pdown_r   <= is_pdown;
        written_r <= 1'b1;
        if (is_pdown)
          term_r <= term_w;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      powered_down <= 1'b0;
      term_2k5     <= 1'b0;
      term_100k    <= 1'b0;
    end
    else
    begin
      powered_down <= pdown_r;
      term_2k5     <= pdown_r & (term_r == TERM_2K5);
      term_100k    <= pdown_r & (term_r == TERM_100K);
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  wire do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wr_ctrl  = do_write & (awaddr_r == `ADDR_CTRL) & wstrb_r[0];
  wire wr_stat  = do_write & (awaddr_r == `ADDR_STATUS) & wstrb_r[0];
  wire wr_ok    = (awaddr_r[1:0] == 2'h0);
  wire rd_ok    = (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] status_w = {27'h0, written_r, err_r, term_r, pdown_r};
  wire [31:0] rd_mux =
    (s_axi_araddr == `ADDR_CTRL)   ? {31'h0, enable_r} :
    (s_axi_araddr == `ADDR_STATUS) ? status_w :
    (s_axi_araddr == `ADDR_CHAN_A) ? 32'(hold_a_r) :
                                     32'(hold_b_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0;
      enable_r      <= 1'b1;
      err_r         <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_got_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_got_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
        enable_r <= wdata_r[`CTRL_ENABLE];
      // Bad lead bit sets the sticky error; set beats a write-one clear
      if (last_edge && !cmd_ok)
        err_r <= 1'b1;
      else if (wr_stat && wdata_r[`STAT_ERR])
        err_r <= 1'b0;
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_mux : 32'h0;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dual_dac_serial_write_control

// ---- dac_ctrl_checker_asserts.sv ----
`timescale 1ns/1ns
module dac_ctrl_checker
  import dac_ctrl_pkg::*;
#(parameter int DATA_BITS = 12)
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 frame_sel_n,
  input wire logic                 serial_clk,
  input wire logic [DATA_BITS-1:0] out_code_a,
  input wire logic [DATA_BITS-1:0] out_code_b,
  input wire logic                 powered_down,
  input wire logic                 term_2k5,
  input wire logic                 term_100k
);
  logic [4:0] ecnt_r;
  logic [4:0] scnt_r;
  logic       sclk_r;
  logic       frm_r;
  wire        fall = sclk_r & ~serial_clk;
  // Raw edges only; the design's sync delay must fit inside these bounds
  always_ff @(posedge aclk)
  begin
    sclk_r <= serial_clk;
    frm_r  <= frame_sel_n;
    if (!aresetn || (frm_r && !frame_sel_n))
      ecnt_r <= 5'h00;
    else if (fall && !frame_sel_n && ecnt_r != 5'h1f)
      ecnt_r <= ecnt_r + 5'h01;
    if (!aresetn || fall)
      scnt_r <= 5'h00;
    else if (scnt_r != 5'h1f)
      scnt_r <= scnt_r + 5'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_act;
    $changed(out_code_a) || $changed(out_code_b) || $changed(powered_down);
  endsequence
  property p_term_excl; !(term_2k5 && term_100k); endproperty
  property p_term_pd; (term_2k5 || term_100k) |-> powered_down; endproperty
  property p_rst_codes;
    $rose(aresetn) |-> out_code_a == '0 && out_code_b == '0;
  endproperty
  property p_rst_flags;
    $rose(aresetn) |-> !powered_down && !term_2k5 && !term_100k;
  endproperty
  property p_near; s_act |-> scnt_r < 5'h0a; endproperty
  property p_edge16; s_act |-> ecnt_r == 5'h10; endproperty
  property p_abort;
    $rose(frame_sel_n) && ecnt_r < 5'h10 |=>
      ($stable(out_code_a) && $stable(out_code_b) && $stable(powered_down))[*8];
  endproperty
  property p_pd_keep;
    $rose(powered_down) |-> $stable(out_code_a) && $stable(out_code_b);
  endproperty
  a_term_excl: assert property (p_term_excl) else $error("two terms");
  a_term_pd: assert property (p_term_pd) else $error("term awake");
  a_rst_codes: assert property (p_rst_codes) else $error("code rst");
  a_rst_flags: assert property (p_rst_flags) else $error("flag rst");
  a_near: assert property (p_near) else $error("change off edge");
  a_edge16: assert property (p_edge16) else $error("not edge 16");
  a_abort: assert property (p_abort) else $error("partial acted");
  a_pd_keep: assert property (p_pd_keep) else $error("pd codes");
  c_pd: cover property ($rose(powered_down));
  c_wake: cover property ($fell(powered_down));
  c_100k: cover property (term_100k);
endmodule // dac_ctrl_checker
bind dual_dac_serial_write_control dac_ctrl_checker #(.DATA_BITS(DATA_BITS))
  u_chk (.aclk, .aresetn, .frame_sel_n, .serial_clk, .out_code_a,
         .out_code_b, .powered_down, .term_2k5, .term_100k);

// ---- serial_host_model.sv ----
`timescale 1ns/1ns
module serial_host_model
(
  output logic frame_sel_n,
  output logic serial_clk,
  output logic serial_data
);
  initial
  begin
    frame_sel_n = 1'b0;
    serial_clk  = 1'b0;
    serial_data = 1'b0;
  end
  // Sends the low n bits of w, top bit first; n may differ from 16 for short or long frames
  task automatic send(input logic [19:0] w, input int n);
    frame_sel_n = 1'b1;
    #20 frame_sel_n = 1'b0;
    #63;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_clk  = 1'b1;
      serial_data = w[i];
      #62 serial_clk = 1'b0;
      #63;
    end
    serial_data = 1'b0;
    #40 frame_sel_n = 1'b1;
    #20 frame_sel_n = 1'b0;
    #40;
  endtask
endmodule // serial_host_model

// ---- dual_dac_serial_write_control_test.sv ----
`timescale 1ns/1ns
module dual_dac_serial_write_control_test
  import dac_ctrl_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, rd_v;
  logic [1:0]  rs_v;
  logic [1:0]  bs_v;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  wire         frame_sel_n, serial_clk, serial_data, powered_down;
  wire         term_2k5, term_100k, s_axi_awready, s_axi_wready;
  wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [11:0]  out_code_a, out_code_b;
  wire [31:0]  s_axi_rdata;
  int          bad_count = 0, comparisons = 0;
  always #2 aclk = ~aclk;
  serial_host_model host (.frame_sel_n, .serial_clk, .serial_data);
  dual_dac_serial_write_control dut (.aclk, .aresetn, .frame_sel_n,
    .serial_clk, .serial_data, .out_code_a, .out_code_b, .powered_down,
    .term_2k5, .term_100k, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task results;
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        bs_v = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd_v = s_axi_rdata;
        rs_v = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_v, e);
  endtask
  task outs(input logic [2:0] f, input logic [11:0] a, input logic [11:0] b);
    chk({5'h0, powered_down, term_2k5, term_100k, out_code_a, out_code_b},
        {5'h0, f, a, b});
  endtask
  task go(input logic [15:0] w);
    host.send({4'h0, w}, 16);
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    outs(3'h0, 12'h000, 12'h000);
    go(16'h05a3);
    outs(3'h0, 12'h000, 12'h000);
    rdc(4'h8, 32'h5a3);
    go(16'h5c3c);
    outs(3'h0, 12'h5a3, 12'hc3c);
    go(16'h27ff);
    outs(3'h0, 12'h7ff, 12'h7ff);
    host.send(20'h00891, 15);
    outs(3'h0, 12'h7ff, 12'h7ff);
    host.send(20'h1001f, 20);
    outs(3'h0, 12'h001, 12'h7ff);
    for (int t = 0; t < 4; t++)
    begin
      go({t[1:0], 14'h3000});
      outs({1'b1, t == 1, t == 2}, 12'h001, 12'h7ff);
      rdc(4'h4, {27'h0, 2'b10, t[1:0], 1'b1});
    end
    go(16'h40f0);
    outs(3'h0, 12'h001, 12'h7ff);
    rdc(4'hc, 32'h0f0);
    rdc(4'h8, 32'h001);
    go(16'h9abc);
    outs(3'h0, 12'h001, 12'h7ff);
    rdc(4'h4, 32'h1e);
    wr(4'h4, 32'h8);
    chk({30'h0, bs_v}, 32'h0);
    rdc(4'h4, 32'h16);
    wr(4'h2, 32'h1);
    chk({30'h0, bs_v}, 32'h2);
    wr(4'h0, 32'h0);
    go(16'h1abc);
    outs(3'h0, 12'h001, 12'h7ff);
    wr(4'h0, 32'h1);
    rdc(4'h0, 32'h1);
    chk({30'h0, rs_v}, 32'h0);
    go(16'h1abc);
    outs(3'h0, 12'habc, 12'h0f0);
    rd(4'h1);
    chk({30'h0, rs_v}, 32'h2);
    chk(rd_v, 32'h0);
    results;
  end
  initial
  begin
    #100000;
    bad_count++;
    results;
  end
endmodule // dual_dac_serial_write_control_test
